// file: core/cmrp_consts.svh
// constants of the parallel configuration readback port
`ifndef CMRP_CONSTS_SVH
`define CMRP_CONSTS_SVH

`define CMRP_SYNC_WORD        32'hAA995566
`define CMRP_WIDTH_SYNC_BYTE  8'hBB
`define CMRP_DETECT_X8        8'h11
`define CMRP_DETECT_X16       8'h22
`define CMRP_DETECT_X32       8'h44

`define CMRP_HDR_TYPE_MSB     31
`define CMRP_HDR_TYPE_LSB     29
`define CMRP_HDR_OP_MSB       28
`define CMRP_HDR_OP_LSB       27
`define CMRP_HDR_REG_MSB      17
`define CMRP_HDR_REG_LSB      13
`define CMRP_HDR_CNT1_MSB     10
`define CMRP_HDR_CNT2_MSB     26
`define CMRP_CMD_CODE_MSB     4

`define CMRP_TYPE1            3'h1
`define CMRP_TYPE2            3'h2
`define CMRP_OP_READ          2'h1
`define CMRP_OP_WRITE         2'h2
`define CMRP_REG_FRAME_ADDR   5'h01
`define CMRP_REG_FRAME_OUT    5'h03
`define CMRP_REG_CMD          5'h04

`define CMRP_CMD_READ_CFG     5'h04
`define CMRP_CMD_START        5'h05
`define CMRP_CMD_RESET_CRC    5'h07
`define CMRP_CMD_SHUTDOWN     5'h0B
`define CMRP_CMD_LEAVE_SYNC   5'h0D

`define CMRP_READ_LATENCY     2'h3
`define CMRP_STARTUP_CLKS     4'h8
`define CMRP_DUMMY_X8         3'h3
`define CMRP_DUMMY_X16        3'h2
`define CMRP_DUMMY_X32        3'h1
`define CMRP_PAD_WORD         32'hFFFFFFFF
`define CMRP_DUMMY_FRAME_WORD 32'h00000000
`define CMRP_DONE_RESET       1'b1

`endif

// file: core/cmrp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module cmrp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk_i,
	input  wire logic             reset_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      fill_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = (fill_r != DEPTH[PW:0]);
	assign out_valid_o = (fill_r != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = store_r[rd_ptr_r];

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			store_r[wr_ptr_r] <= in_data_i;
		end
	end

	// pointers wrap at depth, so depth need not be a power of two
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r   <= '0;
		end else if (flush_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r   <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				fill_r <= fill_r + 1'b1;
			end else if (pop && !push) begin
				fill_r <= fill_r - 1'b1;
			end
		end
	end
endmodule

// file: core/cmrp_pkg.sv
// types of the parallel configuration readback port
package cmrp_pkg;

	typedef enum logic [2:0] {
		CMRP_W8  = 3'b001,
		CMRP_W16 = 3'b010,
		CMRP_W32 = 3'b100
	} cmrp_width_type;

	typedef enum logic [4:0] {
		CMRP_PK_UNSYNC = 5'b00001,
		CMRP_PK_HEADER = 5'b00010,
		CMRP_PK_CMD    = 5'b00100,
		CMRP_PK_ADDR   = 5'b01000,
		CMRP_PK_TYPE2  = 5'b10000
	} cmrp_pk_state_type;

endpackage

// file: core/cmrp_readback.sv
// device end of the parallel configuration port: packet decode and frame readback
// Function
// - a dummy frame precedes real readback data; host discards it
// - done output is low while shutdown runs
// - eight-bit port reads one extra word
// - width-dependent dummy words precede valid data after busy falls
// - three clocks from read select to busy, for all widths
// - data pins are inputs on write select, outputs on read select
// - chip select and read/write select are sampled on the clock, except by the data pin enable, which decodes them directly
`timescale 1ns/100ps
`include "cmrp_consts.svh"
module cmrp_readback import cmrp_pkg::*; #(
	parameter int WORDS_PER_FRAME = 81,
	parameter int FRAMES          = 16,
	parameter int FIFO_DEPTH      = 8,
	parameter int AW              = $clog2(WORDS_PER_FRAME * FRAMES)
) (
	input  wire logic          sys_clk_i,
	input  wire logic          reset_i,
	input  wire logic          chip_select_n_i,
	input  wire logic          read_write_select_n_i,
	input  wire logic [31:0]   data_i,
	output logic      [31:0]   data_o,
	output logic               data_oe_n_o,
	output logic               busy_o,
	output logic               done_o,
	input  wire logic          mem_wr_en_i,
	input  wire logic [AW-1:0] mem_wr_addr_i,
	input  wire logic [31:0]   mem_wr_data_i
);
	localparam int MEM_WORDS = WORDS_PER_FRAME * FRAMES;

	logic [31:0]       frame_mem [MEM_WORDS];
	cmrp_width_type    width_r;
	cmrp_pk_state_type pk_state_r;
	logic [31:0]       win_r;
	logic [31:0]       win_nxt;
	logic              seen_bb_r;
	logic [1:0]        beat_cnt_r;
	logic [1:0]        last_beat;
	logic              word_vld_r;
	logic [31:0]       word_r;
	logic              wr_beat;
	logic              rd_sel;
	logic [31:0]       frame_addr_r;
	logic              read_cfg_r;
	logic              done_r;
	logic [3:0]        start_cnt_r;
	logic              rb_start;
	logic [26:0]       rb_count;
	logic [2:0]        pad_left_r;
	logic [27:0]       fetch_left_r;
	logic [15:0]       dframe_left_r;
	logic [AW-1:0]     addr_r;
	logic              fetch_valid;
	logic [31:0]       fetch_data;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic [31:0]       fifo_out_data;
	logic              take;
	logic [1:0]        lat_cnt_r;
	logic [1:0]        beat_idx_r;
	logic              busy_r;
	logic [31:0]       data_r;

	assign wr_beat     = !chip_select_n_i && !read_write_select_n_i;
	assign rd_sel      = !chip_select_n_i && read_write_select_n_i;
	assign data_oe_n_o = !rd_sel;
	assign data_o      = data_r;
	assign busy_o      = busy_r;
	assign done_o      = done_r;

	always_comb begin
		case (width_r)
			CMRP_W8: begin
				win_nxt   = {win_r[23:0], data_i[7:0]};
				last_beat = 2'h3;
			end
			CMRP_W16: begin
				win_nxt   = {win_r[15:0], data_i[15:0]};
				last_beat = 2'h1;
			end
			default: begin
				win_nxt   = data_i;
				last_beat = 2'h0;
			end
		endcase
	end

	// sync search slides over beats so word alignment follows the sync word
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			win_r      <= 32'h00000000;
			seen_bb_r  <= 1'b0;
			width_r    <= CMRP_W32;
			beat_cnt_r <= 2'h0;
			word_vld_r <= 1'b0;
			word_r     <= 32'h00000000;
		end else begin
			word_vld_r <= 1'b0;
			if (wr_beat) begin
				win_r <= win_nxt;
				if (pk_state_r == CMRP_PK_UNSYNC) begin
					beat_cnt_r <= 2'h0;
					seen_bb_r  <= (data_i[7:0] == `CMRP_WIDTH_SYNC_BYTE);
					if (seen_bb_r) begin
						if (data_i[7:0] == `CMRP_DETECT_X8) begin
							width_r <= CMRP_W8;
						end else if (data_i[7:0] == `CMRP_DETECT_X16) begin
							width_r <= CMRP_W16;
						end else if (data_i[7:0] == `CMRP_DETECT_X32) begin
							width_r <= CMRP_W32;
						end
					end
				end else if (beat_cnt_r == last_beat) begin
					beat_cnt_r <= 2'h0;
					word_vld_r <= 1'b1;
					word_r     <= win_nxt;
				end else begin
					beat_cnt_r <= beat_cnt_r + 2'h1;
				end
			end
		end
	end

	// packet decode; headers to registers outside this block are ignored
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pk_state_r   <= CMRP_PK_UNSYNC;
			frame_addr_r <= 32'h00000000;
		end else begin
			case (pk_state_r)
				CMRP_PK_UNSYNC: begin
					if (wr_beat && win_nxt == `CMRP_SYNC_WORD) begin
						pk_state_r <= CMRP_PK_HEADER;
					end
				end
				CMRP_PK_HEADER: begin
					if (word_vld_r &&
					    word_r[`CMRP_HDR_TYPE_MSB:`CMRP_HDR_TYPE_LSB] == `CMRP_TYPE1) begin
						if (word_r[`CMRP_HDR_OP_MSB:`CMRP_HDR_OP_LSB] == `CMRP_OP_WRITE &&
						    word_r[`CMRP_HDR_CNT1_MSB:0] != 11'h000) begin
							if (word_r[`CMRP_HDR_REG_MSB:`CMRP_HDR_REG_LSB] == `CMRP_REG_CMD) begin
								pk_state_r <= CMRP_PK_CMD;
							end else if (word_r[`CMRP_HDR_REG_MSB:`CMRP_HDR_REG_LSB] ==
							             `CMRP_REG_FRAME_ADDR) begin
								pk_state_r <= CMRP_PK_ADDR;
							end
						end else if (word_r[`CMRP_HDR_OP_MSB:`CMRP_HDR_OP_LSB] == `CMRP_OP_READ &&
						             word_r[`CMRP_HDR_REG_MSB:`CMRP_HDR_REG_LSB] ==
						             `CMRP_REG_FRAME_OUT) begin
							pk_state_r <= CMRP_PK_TYPE2;
						end
					end
				end
				CMRP_PK_CMD: begin
					if (word_vld_r) begin
						if (word_r[`CMRP_CMD_CODE_MSB:0] == `CMRP_CMD_LEAVE_SYNC) begin
							pk_state_r <= CMRP_PK_UNSYNC;
						end else begin
							pk_state_r <= CMRP_PK_HEADER;
						end
					end
				end
				CMRP_PK_ADDR: begin
					if (word_vld_r) begin
						frame_addr_r <= word_r;
						pk_state_r   <= CMRP_PK_HEADER;
					end
				end
				CMRP_PK_TYPE2: begin
					if (word_vld_r) begin
						pk_state_r <= CMRP_PK_HEADER;
					end
				end
				default: pk_state_r <= CMRP_PK_UNSYNC;
			endcase
		end
	end

	// type-2 read after the zero-count frame-output header, only once readback is enabled
	assign rb_start = word_vld_r && pk_state_r == CMRP_PK_TYPE2 && read_cfg_r &&
	                  word_r[`CMRP_HDR_TYPE_MSB:`CMRP_HDR_TYPE_LSB] == `CMRP_TYPE2 &&
	                  word_r[`CMRP_HDR_OP_MSB:`CMRP_HDR_OP_LSB] == `CMRP_OP_READ;
	assign rb_count = word_r[`CMRP_HDR_CNT2_MSB:0];

	// reset-CRC is accepted; no crc is kept because this port only reads back
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_r      <= `CMRP_DONE_RESET;
			read_cfg_r  <= 1'b0;
			start_cnt_r <= 4'h0;
		end else begin
			if (start_cnt_r != 4'h0) begin
				start_cnt_r <= start_cnt_r - 4'h1;
				if (start_cnt_r == 4'h1) begin
					done_r <= 1'b1;
				end
			end
			if (word_vld_r && pk_state_r == CMRP_PK_CMD) begin
				case (word_r[`CMRP_CMD_CODE_MSB:0])
					`CMRP_CMD_SHUTDOWN: begin
						done_r      <= 1'b0;
						start_cnt_r <= 4'h0;
					end
					`CMRP_CMD_READ_CFG: read_cfg_r <= 1'b1;
					`CMRP_CMD_START: begin
						read_cfg_r  <= 1'b0;
						start_cnt_r <= `CMRP_STARTUP_CLKS;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (mem_wr_en_i) begin
			frame_mem[mem_wr_addr_i] <= mem_wr_data_i;
		end
	end

	// fetch order: bus dummy words, then the buffered dummy frame, then memory
	always_comb begin
		fetch_valid = (pad_left_r != 3'h0) || (fetch_left_r != 28'h0);
		if (pad_left_r != 3'h0) begin
			fetch_data = `CMRP_PAD_WORD;
		end else if (dframe_left_r != 16'h0) begin
			fetch_data = `CMRP_DUMMY_FRAME_WORD;
		end else begin
			fetch_data = frame_mem[addr_r];
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pad_left_r    <= 3'h0;
			fetch_left_r  <= 28'h0;
			dframe_left_r <= 16'h0;
			addr_r        <= '0;
		end else if (rb_start) begin
			case (width_r)
				CMRP_W8:  pad_left_r <= `CMRP_DUMMY_X8;
				CMRP_W16: pad_left_r <= `CMRP_DUMMY_X16;
				default:  pad_left_r <= `CMRP_DUMMY_X32;
			endcase
			fetch_left_r  <= {1'b0, rb_count} + ((width_r == CMRP_W8) ? 28'h1 : 28'h0);
			dframe_left_r <= 16'(WORDS_PER_FRAME);
			addr_r        <= AW'((frame_addr_r % FRAMES) * WORDS_PER_FRAME);
		end else if (fetch_valid && fifo_in_ready) begin
			if (pad_left_r != 3'h0) begin
				pad_left_r <= pad_left_r - 3'h1;
			end else begin
				fetch_left_r <= fetch_left_r - 28'h1;
				if (dframe_left_r != 16'h0) begin
					dframe_left_r <= dframe_left_r - 16'h1;
				end else begin
					addr_r <= (addr_r == AW'(MEM_WORDS - 1)) ? '0 : addr_r + 1'b1;
				end
			end
		end
	end

	cmrp_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.flush_i     (rb_start),
		.in_valid_i  (fetch_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fetch_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (take && beat_idx_r == last_beat),
		.out_data_o  (fifo_out_data)
	);

	// busy and data register together, so busy low always marks a valid beat
	assign take = rd_sel && lat_cnt_r == (`CMRP_READ_LATENCY - 2'h1) && fifo_out_valid;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lat_cnt_r  <= 2'h0;
			beat_idx_r <= 2'h0;
			busy_r     <= 1'b1;
			data_r     <= 32'h00000000;
		end else begin
			busy_r <= !take;
			if (!rd_sel) begin
				lat_cnt_r <= 2'h0;
			end else if (lat_cnt_r != (`CMRP_READ_LATENCY - 2'h1)) begin
				lat_cnt_r <= lat_cnt_r + 2'h1;
			end
			if (take) begin
				beat_idx_r <= (beat_idx_r == last_beat) ? 2'h0 : beat_idx_r + 2'h1;
				case (width_r)
					CMRP_W8: begin
						case (beat_idx_r)
							2'h0:    data_r <= {24'h000000, fifo_out_data[31:24]};
							2'h1:    data_r <= {24'h000000, fifo_out_data[23:16]};
							2'h2:    data_r <= {24'h000000, fifo_out_data[15:8]};
							default: data_r <= {24'h000000, fifo_out_data[7:0]};
						endcase
					end
					CMRP_W16: begin
						data_r <= beat_idx_r[0] ? {16'h0000, fifo_out_data[15:0]}
						                        : {16'h0000, fifo_out_data[31:16]};
					end
					default: data_r <= fifo_out_data;
				endcase
			end
		end
	end
endmodule

// file: tb/cmrp_host_model.sv
// behavioural configuration host driving the parallel readback port
`timescale 1ns/100ps
`include "cmrp_consts.svh"
module cmrp_host_model (
	input  wire logic        sys_clk_i,
	input  wire logic        busy_i,
	input  wire logic [31:0] data_i,
	output logic             chip_select_n_o,
	output logic             read_write_select_n_o,
	output logic      [31:0] data_o
);
	localparam logic [31:0] NO_OPERATION_WORD = 32'h20000000;
	logic [31:0] got[$];
	int          first_valid;
	// bytes carried by one beat: 1, 2 or 4
	int          beat_bytes = 4;
	initial begin
		chip_select_n_o = 1'b1;
		read_write_select_n_o = 1'b0;
		data_o = 32'h0;
	end
	// narrow ports take a word as several beats, most significant part first
	task automatic put(input logic [31:0] w);
		logic [31:0] rest;
		rest = w;
		for (int b = 0; b < 4 / beat_bytes; b++) begin
			@(posedge sys_clk_i);
			#1;
			chip_select_n_o = 1'b0;
			read_write_select_n_o = 1'b0;
			case (beat_bytes)
				1: data_o = {24'h0, rest[31:24]};
				2: data_o = {16'h0, rest[31:16]};
				default: data_o = rest;
			endcase
			rest = rest << (8 * beat_bytes);
		end
	endtask
	task automatic idle_words(input int n);
		repeat (n) put(NO_OPERATION_WORD);
	endtask
	task automatic cmd(input logic [4:0] code);
		put(32'h30008001);
		put({27'h0, code});
		idle_words(1);
	endtask
	// deselect first: a direction change while selected would abort the port
	task automatic turn(input logic rw_n);
		repeat (2) begin
			@(posedge sys_clk_i);
			#1;
			chip_select_n_o = 1'b1;
			data_o = ~data_o;
		end
		read_write_select_n_o = rw_n;
	endtask
	// width is chosen first, so the detect sequence already goes out in beats of that width
	task automatic sync_port(input int bb);
		beat_bytes = bb;
		put(32'hFFFFFFFF);
		put({24'h0, `CMRP_WIDTH_SYNC_BYTE});
		put(32'h11220044);
		put(32'hFFFFFFFF);
		put(`CMRP_SYNC_WORD);
		idle_words(1);
	endtask
	task automatic shutdown();
		cmd(`CMRP_CMD_SHUTDOWN);
		cmd(`CMRP_CMD_RESET_CRC);
		idle_words(5);
	endtask
	// cnt already holds the extra dummy frame
	task automatic request(input logic [31:0] frame_addr, input logic [26:0] cnt, input bit cfg);
		if (cfg)
			cmd(`CMRP_CMD_READ_CFG);
		put(32'h30002001);
		put(frame_addr);
		put(32'h28006000);
		put({5'h09, cnt});
		idle_words(32);
	endtask
	task automatic fetch(input int n, input int bound);
		int k;
		got.delete();
		first_valid = -1;
		turn(1'b1);
		@(posedge sys_clk_i);
		#1;
		chip_select_n_o = 1'b0;
		for (k = 0; k < bound && got.size() < n; k++) begin
			@(posedge sys_clk_i);
			#1;
			data_o = ~data_o;
			if (busy_i === 1'b0) begin
				if (first_valid < 0)
					first_valid = k;
				got.push_back(data_i);
			end
		end
		turn(1'b0);
	endtask
	task automatic restart();
		idle_words(1);
		cmd(`CMRP_CMD_START);
		cmd(`CMRP_CMD_RESET_CRC);
		put(32'h30008001);
		put({27'h0, `CMRP_CMD_LEAVE_SYNC});
		idle_words(2);
	endtask
endmodule

// file: tb/cmrp_readback_assertions.sv
// concurrent checks on the pins of the readback port
`timescale 1ns/100ps
module cmrp_readback_checker (
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic chip_select_n_i,
	input  wire logic read_write_select_n_i,
	input  wire logic data_oe_n_o,
	input  wire logic busy_o,
	input  wire logic done_o
);
	wire logic rd = !chip_select_n_i && read_write_select_n_i;
	wire logic wr = !chip_select_n_i && !read_write_select_n_i;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	AST_PINS_TURN: assert property (data_oe_n_o == !rd)
		else $error("pin enable does not follow read select");
	AST_FIRST_READ: assert property (rd && !$past(rd) |=> busy_o ##1 busy_o)
		else $error("busy fell before three read clocks");
	AST_LATENCY_RUN: assert property (!busy_o |-> $past(rd) && $past(rd, 2) && $past(rd, 3))
		else $error("valid beat without three read edges");
	AST_IDLE_BUSY: assert property (!rd |=> busy_o [*3])
		else $error("busy low too soon after leaving read");
	AST_VALID_DRIVEN: assert property (!busy_o |-> !$past(data_oe_n_o))
		else $error("valid beat while pins were not driven");
	AST_DONE_FALL: assert property ($fell(done_o) |-> $past(wr, 2) || $past(wr, 3))
		else $error("done fell without a write word");
	AST_DONE_HOLD: assert property ($fell(done_o) |=> !done_o [*8])
		else $error("done rose during shutdown");
	AST_DONE_RISE: assert property ($rose(done_o) |-> !$past(done_o, 8))
		else $error("done rose without a full startup");
endmodule

bind cmrp_readback cmrp_readback_checker chk_u (
	.sys_clk_i             (sys_clk_i),
	.reset_i               (reset_i),
	.chip_select_n_i       (chip_select_n_i),
	.read_write_select_n_i (read_write_select_n_i),
	.data_oe_n_o           (data_oe_n_o),
	.busy_o                (busy_o),
	.done_o                (done_o)
);

// file: tb/cmrp_readback_test.sv
// self-checking bench for the parallel configuration readback port
`timescale 1ns/100ps
`include "cmrp_consts.svh"
module cmrp_readback_test;
	localparam int WPF = 4;
	localparam int NFR = 4;
	logic        sys_clk;
	logic        reset;
	logic        cs_n;
	logic        rw_select_n;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        oe_n;
	logic        busy;
	logic        done;
	logic        mem_wr_en;
	logic [3:0]  mem_wr_addr;
	logic [31:0] mem_wr_data;
	int          err_total = 0;
	int          num_checks = 0;
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	cmrp_readback #(.WORDS_PER_FRAME(WPF), .FRAMES(NFR)) dut_u (
		.sys_clk_i             (sys_clk),
		.reset_i               (reset),
		.chip_select_n_i       (cs_n),
		.read_write_select_n_i (rw_select_n),
		.data_i                (wdata),
		.data_o                (rdata),
		.data_oe_n_o           (oe_n),
		.busy_o                (busy),
		.done_o                (done),
		.mem_wr_en_i           (mem_wr_en),
		.mem_wr_addr_i         (mem_wr_addr),
		.mem_wr_data_i         (mem_wr_data)
	);
	cmrp_host_model host_u (
		.sys_clk_i             (sys_clk),
		.busy_i                (busy),
		.data_i                (rdata),
		.chip_select_n_o       (cs_n),
		.read_write_select_n_o (rw_select_n),
		.data_o                (wdata)
	);
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// address wraps, as the memory does
	function automatic logic [31:0] mem_word(input int a);
		return 32'hC0DE0000 | 32'(a % (WPF * NFR));
	endfunction
	task automatic load_memory();
		for (int a = 0; a < WPF * NFR; a++) begin
			@(posedge sys_clk);
			#1;
			mem_wr_en = 1'b1;
			mem_wr_addr = 4'(a);
			mem_wr_data = mem_word(a);
		end
		@(posedge sys_clk);
		#1;
		mem_wr_en = 1'b0;
	endtask
	task automatic shutdown_done(input int bb);
		host_u.sync_port(bb);
		chk_word("done before shutdown", 32'h1, {31'h0, done});
		host_u.shutdown();
		chk_word("done in shutdown", 32'h0, {31'h0, done});
	endtask
	// bb is bytes per beat; narrow beats come back high part first, zero-extended
	task automatic readback_frames(input int frame_addr, input int frames, input int bb);
		int          cnt;
		int          per;
		int          pad;
		int          total;
		logic [31:0] exp;
		logic [31:0] w;
		per = 4 / bb;
		cnt = WPF * (frames + 1);
		if (bb == 1)
			pad = `CMRP_DUMMY_X8;
		else if (bb == 2)
			pad = `CMRP_DUMMY_X16;
		else
			pad = `CMRP_DUMMY_X32;
		total = pad + cnt + ((bb == 1) ? 1 : 0);
		host_u.request(32'(frame_addr), 27'(cnt), 1'b1);
		host_u.fetch(total * per, 400);
		chk_word("beat count", 32'(total * per), 32'(host_u.got.size()));
		if (host_u.got.size() != total * per)
			print_verdict();
		chk_word("busy latency", 32'h2, 32'(host_u.first_valid));
		for (int i = 0; i < total; i++) begin
			w = 32'h0;
			for (int b = 0; b < per; b++)
				w = (w << (8 * bb)) | host_u.got[i * per + b];
			if (i < pad)
				exp = `CMRP_PAD_WORD;
			else if (i < pad + WPF)
				exp = `CMRP_DUMMY_FRAME_WORD;
			else
				exp = mem_word(frame_addr * WPF + i - pad - WPF);
			chk_word("readback word", exp, w);
		end
	endtask
	task automatic restart_done();
		int k;
		host_u.restart();
		for (k = 0; k < 50 && done !== 1'b1; k++)
			host_u.idle_words(1);
		chk_word("done after start", 32'h1, {31'h0, done});
		if (done !== 1'b1)
			print_verdict();
	endtask
	// a read header with no read command since the last start is ignored
	task automatic refused_read();
		host_u.sync_port(4);
		host_u.shutdown();
		host_u.request(32'h0, 27'(WPF * 2), 1'b0);
		host_u.fetch(1, 40);
		chk_word("words without read command", 32'h0, 32'(host_u.got.size()));
		host_u.restart();
	endtask
	initial begin
		reset = 1'b1;
		mem_wr_en = 1'b0;
		mem_wr_addr = 4'h0;
		mem_wr_data = 32'h0;
		repeat (16) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		load_memory();
		chk_word("busy after reset", 32'h1, {31'h0, busy});
		shutdown_done(4);
		readback_frames(2, 2, 4);
		restart_done();
		shutdown_done(4);
		readback_frames(3, 2, 4);
		restart_done();
		shutdown_done(1);
		readback_frames(3, 2, 1);
		restart_done();
		shutdown_done(2);
		readback_frames(1, 1, 2);
		restart_done();
		refused_read();
		print_verdict();
	end
endmodule
